// ==== hw/sdac_core.v ====
// serial dac control: shift register, dac register, readback, clear, power
`timescale 1ns/1ps
`default_nettype none
`include "sdac_defs.vh"
module sdac_core #(
  parameter RES = `SDAC_RES_HI,
  parameter WORD = `SDAC_WORD_BITS,
  parameter FDEPTH = `SDAC_FIFO_DEPTH
) (
  // clock and reset
  input wire sys_clk_i,
  input wire reset_n_i,
  // serial link pins
  input wire serial_clk_i,
  input wire frame_n_i,
  input wire serial_in_i,
  input wire load_strobe_n_i,
  input wire readback_enable_n_i,
  output reg serial_out_o,
  output reg serial_out_oe_o,
  // control pins
  input wire output_zero_n_i,
  input wire power_down_n_i,
  // analog side
  output reg [RES-1:0] dac_code_o,
  output reg output_at_ground_ref_o,
  output reg powered_down_o,
  // received word stream, update logic does not wait for it to be drained
  output reg word_valid_o,
  input wire word_ready_i,
  output reg [WORD-1:0] word_data_o
);
  // two-flop synchronisers, first stage read only by second
  reg [4:0] meta_reg;
  reg [4:0] sync_reg;
  reg sclk_d_reg;
  reg zero_d_reg;
  reg frame_d_reg;
  reg readback_enable_n_d_reg;
  always @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      meta_reg <= 5'h1F;
      sync_reg <= 5'h1F;
    end else begin
      meta_reg <= {serial_clk_i, frame_n_i, serial_in_i, load_strobe_n_i,
        readback_enable_n_i};
      sync_reg <= meta_reg;
    end
  end
  wire sclk_s = sync_reg[4];
  wire frame_s = sync_reg[3];
  wire serial_in_s = sync_reg[2];
  wire load_strobe_n_s = sync_reg[1];
  wire readback_enable_n_s = sync_reg[0];
  reg zero_m_reg;
  reg zero_s_reg;
  reg pd_m_reg;
  reg pd_s_reg;
  always @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      zero_m_reg <= 1'b1;
      zero_s_reg <= 1'b1;
      pd_m_reg <= 1'b1;
      pd_s_reg <= 1'b1;
    end else begin
      zero_m_reg <= output_zero_n_i;
      zero_s_reg <= zero_m_reg;
      pd_m_reg <= power_down_n_i;
      pd_s_reg <= pd_m_reg;
    end
  end
  wire sclk_fall = sclk_d_reg & ~sclk_s;
  wire frame_fall = frame_d_reg & ~frame_s;
  wire frame_rise = ~frame_d_reg & frame_s;
  wire zero_fall = zero_d_reg & ~zero_s_reg;
  wire zero_rise = ~zero_d_reg & zero_s_reg;
  wire readback_enable_n_fall = readback_enable_n_d_reg & ~readback_enable_n_s;
  // fifo holds completed words between frame end and dac update
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [WORD-1:0] fifo_out_data;
  reg fifo_push_reg;
  reg [WORD-1:0] fifo_word_reg;
  wire fifo_pop;
  sdac_fifo #(
    .WIDTH(WORD),
    .DEPTH(FDEPTH),
    .AW(3)
  ) u_fifo (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .in_valid_i(fifo_push_reg),
    .in_ready_o(fifo_in_ready),
    .in_data_i(fifo_word_reg),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_pop),
    .out_data_o(fifo_out_data)
  );
  reg [WORD-1:0] shift_reg;
  reg [`SDAC_CNT_W-1:0] bit_cnt_reg;
  reg in_frame_reg;
  reg sync_mode_reg;
  reg rb_arm_reg;
  reg rb_active_reg;
  reg pend_valid_reg;
  reg [WORD-1:0] pend_word_reg;
  reg [RES-1:0] dac_reg;
  reg cleared_reg;
  reg restore_reg;
  // only the low RES bits carry the code, straight binary
  wire [RES-1:0] fifo_code = fifo_out_data[RES-1:0];
  wire [RES-1:0] pend_code = pend_word_reg[RES-1:0];
  // two top bits of readback word are zero
  wire [WORD-1:0] rb_word = {{(WORD-RES){1'b0}}, dac_reg};
  // fifo drains into the pending word only while no update is pending
  assign fifo_pop = fifo_out_valid & ~pend_valid_reg;
  always @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sclk_d_reg <= 1'b1;
      frame_d_reg <= 1'b1;
      zero_d_reg <= 1'b1;
      readback_enable_n_d_reg <= 1'b1;
      shift_reg <= {WORD{1'b0}};
      bit_cnt_reg <= {`SDAC_CNT_W{1'b0}};
      in_frame_reg <= 1'b0;
      sync_mode_reg <= 1'b0;
      rb_arm_reg <= 1'b0;
      rb_active_reg <= 1'b0;
      fifo_push_reg <= 1'b0;
      fifo_word_reg <= {WORD{1'b0}};
      pend_valid_reg <= 1'b0;
      pend_word_reg <= {WORD{1'b0}};
      dac_reg <= {RES{1'b0}};
      cleared_reg <= 1'b0;
      restore_reg <= 1'b0;
      serial_out_o <= 1'b0;
      serial_out_oe_o <= 1'b0;
      dac_code_o <= {RES{1'b0}};
      output_at_ground_ref_o <= 1'b0;
      powered_down_o <= 1'b0;
      word_valid_o <= 1'b0;
      word_data_o <= {WORD{1'b0}};
    end else begin
      sclk_d_reg <= sclk_s;
      frame_d_reg <= frame_s;
      zero_d_reg <= zero_s_reg;
      readback_enable_n_d_reg <= readback_enable_n_s;
      fifo_push_reg <= 1'b0;
      if (readback_enable_n_fall) begin
        rb_arm_reg <= 1'b1;
      end
      if (frame_fall) begin
        in_frame_reg <= 1'b1;
        bit_cnt_reg <= {`SDAC_CNT_W{1'b0}};
        sync_mode_reg <= ~load_strobe_n_s;
      end
      if (sclk_fall) begin
        if (rb_arm_reg && !readback_enable_n_s) begin
          // msb goes out now, so sixteen falls carry the whole word
          shift_reg <= {rb_word[WORD-2:0], 1'b0};
          rb_arm_reg <= 1'b0;
          rb_active_reg <= 1'b1;
        end else if (in_frame_reg && !frame_s) begin
          shift_reg <= {shift_reg[WORD-2:0], serial_in_s};
          if (bit_cnt_reg != WORD[`SDAC_CNT_W-1:0]) begin
            bit_cnt_reg <= bit_cnt_reg + 1'b1;
          end
        end else if (rb_active_reg) begin
          shift_reg <= {shift_reg[WORD-2:0], 1'b0};
        end
        // msb leaves on the same falling edge a new bit enters
        serial_out_o <= shift_reg[WORD-1];
        serial_out_oe_o <= ~shift_reg[WORD-1];
        if (rb_arm_reg && !readback_enable_n_s) begin
          serial_out_o <= rb_word[WORD-1];
          serial_out_oe_o <= ~rb_word[WORD-1];
        end
      end
      if (readback_enable_n_s && !rb_arm_reg) begin
        rb_active_reg <= 1'b0;
      end
      if (frame_rise && in_frame_reg) begin
        in_frame_reg <= 1'b0;
        // partial words are dropped, not loaded
        if (bit_cnt_reg == WORD[`SDAC_CNT_W-1:0]) begin
          word_data_o <= shift_reg;
          word_valid_o <= 1'b1;
          fifo_word_reg <= shift_reg;
          fifo_push_reg <= fifo_in_ready;
          restore_reg <= sync_mode_reg;
        end
      end
      if (word_valid_o && word_ready_i) begin
        word_valid_o <= 1'b0;
      end
      if (fifo_pop) begin
        pend_valid_reg <= 1'b1;
        pend_word_reg <= fifo_out_data;
      end
      // load at frame end if sync mode, else on strobe low later
      if (pend_valid_reg && (restore_reg || !load_strobe_n_s)) begin
        dac_reg <= pend_code;
        pend_valid_reg <= 1'b0;
        restore_reg <= 1'b0;
      end
      if (zero_fall) begin
        cleared_reg <= 1'b1;
      end else if (zero_rise && !load_strobe_n_s) begin
        cleared_reg <= 1'b0;
      end else if (zero_s_reg && !load_strobe_n_s) begin
        cleared_reg <= 1'b0;
      end
      // power state never touches dac_reg
      powered_down_o <= ~pd_s_reg;
      output_at_ground_ref_o <= cleared_reg;
      dac_code_o <= cleared_reg ? {RES{1'b0}} : dac_reg;
    end
  end
  wire unused_ok = &{1'b0, fifo_code};
endmodule // sdac_core
`default_nettype wire

// ==== include/sdac_defs.vh ====
// constants for the serial dac load and readback block
`ifndef SDAC_DEFS_VH
`define SDAC_DEFS_VH
`define SDAC_WORD_BITS 16
`define SDAC_RES_HI 14
`define SDAC_RES_LO 12
`define SDAC_CNT_W 5
`define SDAC_FIFO_DEPTH 8
`define SDAC_SYNC_STAGES 2
`endif

// ==== hw/sdac_fifo.v ====
// parameterised flip-flop fifo with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module sdac_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  // clock and reset
  input wire sys_clk_i,
  input wire reset_n_i,
  // fill side
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [WIDTH-1:0] in_data_i,
  // drain side
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);
  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [AW-1:0] wr_reg;
  reg [AW-1:0] rd_reg;
  reg [AW:0] cnt_reg;
  wire push;
  wire pop;
  assign in_ready_o = (cnt_reg != DEPTH[AW:0]);
  assign out_valid_o = (cnt_reg != {(AW+1){1'b0}});
  assign out_data_o = mem_reg[rd_reg];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;
  always @(posedge sys_clk_i) begin
    if (push) begin
      mem_reg[wr_reg] <= in_data_i;
    end
  end
  always @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_reg <= {AW{1'b0}};
      rd_reg <= {AW{1'b0}};
      cnt_reg <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_reg <= (wr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
          wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= (rd_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
          rd_reg + 1'b1;
      end
      if (push & ~pop) begin
        cnt_reg <= cnt_reg + 1'b1;
      end else if (pop & ~push) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end
endmodule // sdac_fifo
`default_nettype wire

// ==== testbench/sdac_props.sv ====
// port checks for the serial dac core
`timescale 1ns/1ps
`default_nettype none
module sdac_props #(parameter RES = 14, parameter WORD = 16) (
  // inputs
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic serial_clk_i,
  input wire logic frame_n_i,
  input wire logic load_strobe_n_i,
  input wire logic output_zero_n_i,
  input wire logic power_down_n_i,
  input wire logic word_ready_i,
  // outputs
  input wire logic serial_out_o,
  input wire logic serial_out_oe_o,
  input wire logic [RES-1:0] dac_code_o,
  input wire logic output_at_ground_ref_o,
  input wire logic powered_down_o,
  input wire logic word_valid_o,
  input wire logic [WORD-1:0] word_data_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  clr_zero_a: assert property (
    output_at_ground_ref_o |-> dac_code_o == '0) else $error("clr code");
  clr_flag_a: assert property (
    $fell(output_zero_n_i) |-> ##[1:6] output_at_ground_ref_o)
    else $error("clr late");
  pd_on_a: assert property (
    !power_down_n_i [*6] |-> powered_down_o) else $error("pd late");
  pd_keep_a: assert property (
    $changed(powered_down_o) |-> $stable(dac_code_o)) else $error("pd code");
  oe_pol_a: assert property (
    serial_out_oe_o |-> !serial_out_o) else $error("oe level");
  so_quiet_a: assert property (
    serial_clk_i [*8] |-> $stable(serial_out_o)) else $error("so moved");
  word_hold_a: assert property (
    word_valid_o && !word_ready_i |=> word_valid_o && $stable(word_data_o))
    else $error("word lost");
  dac_quiet_a: assert property (
    (!frame_n_i && load_strobe_n_i && output_zero_n_i) [*6]
    |-> $stable(dac_code_o)) else $error("early update");
  cover property ($rose(output_at_ground_ref_o));
  cover property ($rose(powered_down_o));
  cover property (word_valid_o && !word_ready_i);
endmodule // sdac_props
bind sdac_core sdac_props #(.RES(RES), .WORD(WORD)) props_u (.sys_clk_i,
  .reset_n_i, .serial_clk_i, .frame_n_i, .load_strobe_n_i, .output_zero_n_i,
  .power_down_n_i, .word_ready_i, .serial_out_o, .serial_out_oe_o,
  .dac_code_o, .output_at_ground_ref_o, .powered_down_o, .word_valid_o,
  .word_data_o);
`default_nettype wire

// ==== testbench/sdac_host.sv ====
// host serial port model for the dac link
`timescale 1ns/1ps
`default_nettype none
module sdac_host (
  // link pins, clock idles high between frames
  output var logic sclk_o = 1'b1,
  output var logic frame_n_o = 1'b1,
  output var logic sdi_o = 1'b0,
  output var logic rb_n_o = 1'b1,
  input wire logic sdo_i
);
  task automatic xfer(input logic [15:0] w, input int n, input logic rb,
    output logic [15:0] got);
    got = 16'h0000;
    #40;
    if (rb) rb_n_o = 1'b0; // held for the whole word
    else frame_n_o = 1'b0; // one device framed
    #40;
    for (int i = 0; i < n; i++) begin // frame spans both bytes
      sdi_o = w[15-i]; // msb first, set at the rise
      sclk_o = 1'b1;
      #20 sclk_o = 1'b0;
      #42 got = {got[14:0], sdo_i};
      #2;
    end
    frame_n_o = 1'b1;
    rb_n_o = 1'b1;
    sclk_o = 1'b1;
    sdi_o = !sdi_o; // line flips after the frame, core ignores it
    #80;
  endtask
endmodule // sdac_host
`default_nettype wire

// ==== testbench/serial_dac_load_and_readback_bench.sv ====
// bench for the serial dac core
`timescale 1ns/1ps
`default_nettype none
module serial_dac_load_and_readback_bench;
  typedef struct {logic [15:0] w; logic ld; logic [13:0] e;} sdac_row_t;
  logic sys_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic ld_n = 1'b1;
  logic zero_n = 1'b1;
  logic pd_n = 1'b1;
  logic rdy = 1'b1;
  logic [15:0] got;
  wire sclk, fr_n, sdi, rb_n, so, so_oe, gnd, pd, wv;
  wire [13:0] code;
  wire [15:0] wd;
  int fails = 0;
  int compares = 0;
  sdac_row_t rows[4] = '{'{16'hFFFF, 1'b0, 14'h3FFF},
    '{16'h0000, 1'b0, 14'h0000}, '{16'hC5A5, 1'b1, 14'h0000},
    '{16'h2D3C, 1'b0, 14'h2D3C}};
  always #4 sys_clk_i = ~sys_clk_i;
  // open-drain output pulled up on the board
  sdac_host host_u (.sclk_o(sclk), .frame_n_o(fr_n), .sdi_o(sdi),
    .rb_n_o(rb_n), .sdo_i(!so_oe));
  sdac_core #(.RES(14)) dut_u (.sys_clk_i, .reset_n_i, .serial_clk_i(sclk),
    .frame_n_i(fr_n), .serial_in_i(sdi), .load_strobe_n_i(ld_n),
    .readback_enable_n_i(rb_n), .serial_out_o(so), .serial_out_oe_o(so_oe),
    .output_zero_n_i(zero_n), .power_down_n_i(pd_n), .dac_code_o(code),
    .output_at_ground_ref_o(gnd), .powered_down_o(pd),
    .word_valid_o(wv), .word_ready_i(rdy), .word_data_o(wd));
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask
  task automatic chk(input logic [15:0] a, input logic [15:0] e);
    compares++;
    if (a !== e) begin
      fails++;
      $display("wrong value t=%0t got=%h exp=%h", $time, a, e);
    end
  endtask
  task automatic summarize;
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    step(12);
    chk({wv, 1'b0, code}, 16'h0000);
    reset_n_i = 1'b1;
    step(4);
    foreach (rows[k]) begin
      ld_n = rows[k].ld;
      host_u.xfer(rows[k].w, 16, 1'b0, got);
      step(8);
      chk({2'h0, code}, {2'h0, rows[k].e});
    end
    ld_n = 1'b1;
    host_u.xfer(16'h1234, 16, 1'b0, got);
    step(8);
    chk({2'h0, code}, 16'h2D3C);
    ld_n = 1'b0;
    step(8);
    chk({2'h0, code}, 16'h1234);
    host_u.xfer(16'h0ABC, 15, 1'b0, got);
    step(8);
    chk({2'h0, code}, 16'h1234);
    ld_n = 1'b1;
    host_u.xfer(16'hA55A, 16, 1'b0, got);
    host_u.xfer(16'hFF0F, 16, 1'b0, got);
    chk(got, 16'hA55A);
    step(2);
    ld_n = 1'b0;
    step(8);
    host_u.xfer(16'h0000, 16, 1'b1, got);
    chk(got, 16'h3F0F);
    step(2);
    rdy = 1'b0;
    host_u.xfer(16'h1357, 16, 1'b0, got);
    step(8);
    chk({wv, 15'h0000}, 16'h8000);
    chk(wd, 16'h1357);
    rdy = 1'b1;
    step(8);
    chk({2'h0, code}, 16'h1357);
    pd_n = 1'b0;
    step(8);
    chk({pd, 1'b0, code}, 16'h9357);
    pd_n = 1'b1;
    ld_n = 1'b1;
    step(8);
    chk({pd, 1'b0, code}, 16'h1357);
    zero_n = 1'b0;
    step(8);
    chk({gnd, 1'b0, code}, 16'h8000);
    zero_n = 1'b1;
    step(8);
    chk({gnd, 15'h0000}, 16'h8000);
    ld_n = 1'b0;
    step(8);
    chk({gnd, 1'b0, code}, 16'h1357);
    summarize();
  end
  // hang guard
  initial begin
    #400000;
    fails++;
    summarize();
  end
endmodule // serial_dac_load_and_readback_bench
`default_nettype wire
